// file: hdl/macu_top.sv
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`include "macu_defines.svh"
module macu_top (
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire logic [`MACU_ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [`MACU_BUS_W-1:0] avs_writedata_i,
  input  wire logic [`MACU_BE_W-1:0]  avs_byteenable_i,
  output logic [`MACU_BUS_W-1:0]      avs_readdata_o,
  output logic                        avs_waitrequest_o
);

  macu_pkg::macu_st_t      st_ff;    // all registered state
  macu_pkg::macu_st_t      nxt_st;   // next state
  macu_pkg::macu_mul_req_t mul_req;  // request to multiplier
  logic [`MACU_ACC_W-1:0]  mul_prod; // sign-extended product
  logic                    mul_done; // product valid pulse
  logic [`MACU_IDX_W-1:0]  idx;      // word index from byte address
  logic                    req_any;  // read or write pending
  logic                    wr_ok;    // write taken this edge
  logic                    apply;    // result lands this edge
  logic [`MACU_ACC_W-1:0]  result;   // latest operation result

  // merge a 16-bit register with the enabled low byte lanes
  function automatic logic [`MACU_W-1:0] merge16(
    input logic [`MACU_W-1:0]     old_v,
    input logic [`MACU_BUS_W-1:0] wd,
    input logic [`MACU_BE_W-1:0]  be
  );
    logic [`MACU_W-1:0] v;
    v = old_v;
    if (be[0])
    begin
      v[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction : merge16

  // word decode, low two address bits ignored
  assign idx = avs_address_i[`MACU_ADDR_W-1:2];

  // every access waits at least one cycle, longer while an operation runs, so read data comes from a flop
  assign req_any           = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req_any & ~st_ff.ack;
  assign avs_readdata_o    = st_ff.rdata;
  assign wr_ok             = avs_write_i & st_ff.ack;

  // multiplier fed straight from the operand registers
  assign mul_req.opa   = st_ff.opa;
  assign mul_req.opb   = st_ff.opb;
  assign mul_req.sgn   = st_ff.ctrl.sgn;
  assign mul_req.start = (st_ff.fsm == macu_pkg::MACU_ST_CALC);
  assign apply         = (st_ff.fsm == macu_pkg::MACU_ST_WAIT) & mul_done;

  macu_mul u_mul (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .req_i  (mul_req),
    .prod_o (mul_prod),
    .done_o (mul_done)
  );

  // result of the selected operation, wraps at 48 bits
  always_comb
  begin
    case (st_ff.ctrl.op)
      macu_pkg::MACU_OP_MUL:  result = mul_prod;                 // RULE14
      macu_pkg::MACU_OP_MAC:  result = st_ff.acc + mul_prod;     // RULE14
      macu_pkg::MACU_OP_MSUB: result = st_ff.acc - mul_prod;     // RULE14
      default:                result = `MACU_RST_ACC - mul_prod; // RULE14
    endcase
  end

  // bus, register file and sequencer next state
  always_comb
  begin
    nxt_st = st_ff;
    // ack only while idle: a running operation stalls the bus
    nxt_st.ack = req_any & ~st_ff.ack & (st_ff.fsm == macu_pkg::MACU_ST_IDLE);

    // read data captured the cycle before the answer
    if (req_any & ~st_ff.ack)
    begin
      nxt_st.rdata = `MACU_RST_BUS;
      if (idx == `MACU_IDX_CTRL)
      begin
        nxt_st.rdata[`MACU_CTRL_W-1:0] = st_ff.ctrl;
        nxt_st.rdata[`MACU_CTRL_BUSY_BIT] = (st_ff.fsm != macu_pkg::MACU_ST_IDLE);
      end
      else if (idx == `MACU_IDX_OPA)
      begin
        nxt_st.rdata[`MACU_W-1:0] = st_ff.opa;
      end
      else if (idx == `MACU_IDX_OPB)
      begin
        nxt_st.rdata[`MACU_W-1:0] = st_ff.opb; // RULE3
      end
      else if (idx == `MACU_IDX_ACC_U)
      begin
        nxt_st.rdata[`MACU_W-1:0] = st_ff.acc[47:32]; // RULE7
      end
      else if (idx == `MACU_IDX_ACC_M)
      begin
        nxt_st.rdata[`MACU_W-1:0] = st_ff.acc[31:16]; // RULE7
      end
      else if (idx == `MACU_IDX_ACC_L)
      begin
        nxt_st.rdata[`MACU_W-1:0] = st_ff.acc[15:0]; // RULE7
      end
      else if (idx == `MACU_IDX_VW_M)
      begin
        nxt_st.rdata[`MACU_W-1:0] = st_ff.view_mid;
      end
      else if (idx == `MACU_IDX_VW_L)
      begin
        nxt_st.rdata[`MACU_W-1:0] = st_ff.view_low;
      end
      // unmapped words read as zero
    end

    // writes take effect only at the accepting edge
    if (wr_ok)
    begin
      if (idx == `MACU_IDX_CTRL)
      begin
        if (avs_byteenable_i[0])
        begin
          nxt_st.ctrl = macu_pkg::macu_ctrl_t'(avs_writedata_i[`MACU_CTRL_W-1:0]);
        end
      end
      else if (idx == `MACU_IDX_OPA)
      begin
        nxt_st.opa  = merge16(st_ff.opa, avs_writedata_i, avs_byteenable_i);
        nxt_st.a_ld = 1'b1;
      end
      else if (idx == `MACU_IDX_OPB)
      begin
        nxt_st.opb  = merge16(st_ff.opb, avs_writedata_i, avs_byteenable_i); // RULE3
        nxt_st.b_ld = 1'b1;
      end
      else if (idx == `MACU_IDX_ACC_U)
      begin
        nxt_st.acc[47:32] = merge16(st_ff.acc[47:32], avs_writedata_i,
                                    avs_byteenable_i); // RULE6
      end
      else if (idx == `MACU_IDX_ACC_M)
      begin
        nxt_st.acc[31:16] = merge16(st_ff.acc[31:16], avs_writedata_i,
                                    avs_byteenable_i); // RULE6
      end
      else if (idx == `MACU_IDX_ACC_L)
      begin
        nxt_st.acc[15:0] = merge16(st_ff.acc[15:0], avs_writedata_i,
                                   avs_byteenable_i); // RULE6
      end
      // views are read only, other words ignore writes
    end

    // sequencer
    case (st_ff.fsm)
      macu_pkg::MACU_ST_IDLE:
      begin
        // both operands loaded since the last start
        if (nxt_st.a_ld & nxt_st.b_ld)
        begin
          nxt_st.fsm = macu_pkg::MACU_ST_CALC; // RULE2
        end
      end
      macu_pkg::MACU_ST_CALC:
      begin
        // start pulse goes out, load flags rearm
        nxt_st.a_ld = 1'b0;
        nxt_st.b_ld = 1'b0;
        nxt_st.fsm  = macu_pkg::MACU_ST_WAIT;
      end
      macu_pkg::MACU_ST_WAIT:
      begin
        if (apply)
        begin
          if (!st_ff.ctrl.inhibit)
          begin
            nxt_st.acc = result; // RULE5 RULE12
          end
          // views take the fresh result whether or not it was stored;
          // with accumulate and write-back they equal the new words
          nxt_st.view_mid = result[31:16]; // RULE9 RULE10
          nxt_st.view_low = result[15:0];  // RULE13
          nxt_st.fsm      = macu_pkg::MACU_ST_IDLE;
        end
      end
      default:
      begin
        // illegal code recovers to idle
        nxt_st.fsm = macu_pkg::MACU_ST_IDLE;
      end
    endcase
  end

  // state register, views only move on apply so they hold in between
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_ff.fsm      <= macu_pkg::MACU_ST_IDLE;
      st_ff.ctrl     <= macu_pkg::macu_ctrl_t'(`MACU_RST_CTRL);
      st_ff.opa      <= `MACU_RST_W16;
      st_ff.opb      <= `MACU_RST_W16;      // RULE1
      st_ff.acc      <= `MACU_RST_ACC;      // RULE1
      st_ff.view_mid <= `MACU_RST_W16;      // RULE1
      st_ff.view_low <= `MACU_RST_W16;
      st_ff.a_ld     <= 1'b0;
      st_ff.b_ld     <= 1'b0;
      st_ff.ack      <= 1'b0;
      st_ff.rdata    <= `MACU_RST_BUS;
    end
    else
    begin
      st_ff <= nxt_st; // RULE11
    end
  end

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // reset leaves operand b, accumulator and middle view at zero
  property p_reset_clear;
    $rose(nrst_i) |-> (st_ff.opb == `MACU_RST_W16) && (st_ff.acc == `MACU_RST_ACC)
                      && (st_ff.view_mid == `MACU_RST_W16);
  endproperty
  a_reset_clear: assert property (p_reset_clear) // RULE1
    else $error("state not cleared by reset");

  // both flags set only while the start is being issued
  property p_start;
    (st_ff.a_ld && st_ff.b_ld) |-> (st_ff.fsm == macu_pkg::MACU_ST_CALC)
                                   ##1 (st_ff.fsm == macu_pkg::MACU_ST_WAIT);
  endproperty
  a_start: assert property (p_start) // RULE2
    else $error("operation not started after both loads");

  // full-word write to operand b is stored as written
  property p_opb_wr;
    (wr_ok && idx == `MACU_IDX_OPB && avs_byteenable_i == 4'hF)
      |=> st_ff.opb == $past(avs_writedata_i[15:0]);
  endproperty
  a_opb_wr: assert property (p_opb_wr) // RULE3
    else $error("operand b write lost");

  // operation completes within three cycles of the start
  property p_latency;
    (st_ff.fsm == macu_pkg::MACU_ST_CALC) |-> ##[1:3] (st_ff.fsm == macu_pkg::MACU_ST_IDLE);
  endproperty
  a_latency: assert property (p_latency) // RULE5
    else $error("operation did not finish");

  // inhibit keeps accumulator, otherwise it takes the result
  property p_writeback;
    apply |=> (st_ff.acc == ($past(st_ff.ctrl.inhibit) ? $past(st_ff.acc) : $past(result)));
  endproperty
  a_writeback: assert property (p_writeback) // RULE12
    else $error("accumulator write-back wrong");

  // upper word write lands in bits 47:32
  property p_upper_wr;
    (wr_ok && idx == `MACU_IDX_ACC_U && avs_byteenable_i == 4'hF)
      |=> st_ff.acc[47:32] == $past(avs_writedata_i[15:0]);
  endproperty
  a_upper_wr: assert property (p_upper_wr) // RULE6
    else $error("upper accumulator word write lost");

  // middle word read returns bytes 3 and 2
  property p_mid_rd;
    (avs_read_i && !avs_waitrequest_o && idx == `MACU_IDX_ACC_M)
      |-> avs_readdata_o == {16'h0000, st_ff.acc[31:16]};
  endproperty
  a_mid_rd: assert property (p_mid_rd) // RULE7
    else $error("middle word read wrong");

  // signed plain multiply sign-extends through the upper word
  property p_sign;
    (apply && st_ff.ctrl.sgn && !st_ff.ctrl.inhibit && st_ff.ctrl.op == macu_pkg::MACU_OP_MUL)
      |=> st_ff.acc[47] == st_ff.acc[33];
  endproperty
  a_sign: assert property (p_sign) // RULE8
    else $error("sign bit not extended");

  // views show the latest result
  property p_views;
    apply |=> (st_ff.view_mid == $past(result[31:16]))
              && (st_ff.view_low == $past(result[15:0]));
  endproperty
  a_views: assert property (p_views) // RULE9
    else $error("result views wrong");

  // views hold outside a result landing
  property p_view_hold;
    !apply |=> $stable(st_ff.view_mid) && $stable(st_ff.view_low);
  endproperty
  a_view_hold: assert property (p_view_hold) // RULE11
    else $error("result view changed without operation");

  // main scenarios
  property p_cov_mac;
    apply && st_ff.ctrl.op == macu_pkg::MACU_OP_MAC && !st_ff.ctrl.inhibit;
  endproperty
  c_mac: cover property (p_cov_mac);

  property p_cov_msub;
    apply && st_ff.ctrl.op == macu_pkg::MACU_OP_MSUB;
  endproperty
  c_msub: cover property (p_cov_msub);

  property p_cov_neg_signed;
    apply && st_ff.ctrl.op == macu_pkg::MACU_OP_NEG && st_ff.ctrl.sgn;
  endproperty
  c_neg_signed: cover property (p_cov_neg_signed);

  property p_cov_inhibit;
    apply && st_ff.ctrl.inhibit;
  endproperty
  c_inhibit: cover property (p_cov_inhibit);

endmodule : macu_top

// file: hdl/macu_defines.svh
// Function
// RULE1 - every reset clears operand B, accumulator, views
// RULE2 - loading both operands starts selected operation
// RULE3 - operand B holds full sixteen-bit software value
// RULE4 - signedness select makes operands signed or unsigned
// RULE5 - result goes to accumulator unless inhibited
// RULE6 - 48-bit accumulator as three writable words
// RULE7 - upper, middle, lower words hold byte pairs
// RULE8 - upper word top bit is signed sign
// RULE9 - middle view shows result bytes 3, 2
// RULE10 - middle view may differ for accumulate, subtract
// RULE11 - views hold until multiplier registers change
// RULE12 - inhibit clear writes accumulator, set keeps it
// RULE13 - low view shows result bytes 1, 0
// RULE14 - op select: multiply, accumulate, subtract, negate
`ifndef MACU_DEFINES_SVH
`define MACU_DEFINES_SVH

// data widths
`define MACU_W        16
`define MACU_ACC_W    48
`define MACU_PROD_W   34
`define MACU_BUS_W    32
`define MACU_ADDR_W   6
`define MACU_IDX_W    4
`define MACU_BE_W     4
`define MACU_CTRL_W   4

// register indices, byte address is index times four
`define MACU_IDX_CTRL  4'h0
`define MACU_IDX_OPA   4'h1
`define MACU_IDX_OPB   4'h2
`define MACU_IDX_ACC_U 4'h3
`define MACU_IDX_ACC_M 4'h4
`define MACU_IDX_ACC_L 4'h5
`define MACU_IDX_VW_M  4'h8
`define MACU_IDX_VW_L  4'h9

// control word: bit 4 busy bit, read only, always reads zero since reads are answered only when idle
`define MACU_CTRL_BUSY_BIT 4

// reset values
`define MACU_RST_W16  16'h0000
`define MACU_RST_ACC  48'h000000000000
`define MACU_RST_BUS  32'h00000000
`define MACU_RST_CTRL 4'h0

`endif

// file: hdl/macu_pkg.sv
`include "macu_defines.svh"
package macu_pkg;

  // operation select encodings
  typedef enum logic [1:0] {
    MACU_OP_MUL  = 2'h0,
    MACU_OP_MAC  = 2'h1,
    MACU_OP_MSUB = 2'h2,
    MACU_OP_NEG  = 2'h3
  } macu_op_t;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    MACU_ST_IDLE = 3'h1,
    MACU_ST_CALC = 3'h2,
    MACU_ST_WAIT = 3'h4
  } macu_fsm_t;

  // control word, bit 3 inhibit, bit 2 signed, bits 1:0 op
  typedef struct packed {
    logic     inhibit;
    logic     sgn;
    macu_op_t op;
  } macu_ctrl_t;

  // request to the multiplier
  typedef struct packed {
    logic [`MACU_W-1:0] opa;
    logic [`MACU_W-1:0] opb;
    logic               sgn;
    logic               start;
  } macu_mul_req_t;

  // multiplier state
  typedef struct packed {
    logic [`MACU_ACC_W-1:0] prod;
    logic                   done;
  } macu_mul_st_t;

  // whole state of the top
  typedef struct packed {
    macu_fsm_t              fsm;
    macu_ctrl_t             ctrl;
    logic [`MACU_W-1:0]     opa;
    logic [`MACU_W-1:0]     opb;
    logic [`MACU_ACC_W-1:0] acc;
    logic [`MACU_W-1:0]     view_mid;
    logic [`MACU_W-1:0]     view_low;
    logic                   a_ld;
    logic                   b_ld;
    logic                   ack;
    logic [`MACU_BUS_W-1:0] rdata;
  } macu_st_t;

endpackage : macu_pkg

// file: hdl/macu_mul.sv
`timescale 1ns/1ps
`include "macu_defines.svh"
module macu_mul (
  input  wire logic                   clk_i,
  input  wire logic                   nrst_i,
  input  wire macu_pkg::macu_mul_req_t req_i,
  output logic [`MACU_ACC_W-1:0]      prod_o,
  output logic                        done_o
);

  macu_pkg::macu_mul_st_t          st_ff;  // registered product
  macu_pkg::macu_mul_st_t          nxt_st; // next product
  logic signed [`MACU_W:0]         a_ext;  // operand a, one bit wider
  logic signed [`MACU_W:0]         b_ext;  // operand b, one bit wider
  logic signed [`MACU_PROD_W-1:0]  p_full; // exact product

  // extend by sign or zero so one signed multiplier serves both types
  always_comb
  begin
    a_ext  = {req_i.sgn & req_i.opa[`MACU_W-1], req_i.opa}; // RULE4
    b_ext  = {req_i.sgn & req_i.opb[`MACU_W-1], req_i.opb}; // RULE4
    p_full = a_ext * b_ext;
    nxt_st = st_ff;
    nxt_st.done = req_i.start;
    if (req_i.start)
    begin
      // sign-extend so the accumulator top bit carries the sign
      nxt_st.prod = {{(`MACU_ACC_W-`MACU_PROD_W){p_full[`MACU_PROD_W-1]}}, p_full}; // RULE8
    end
  end

  // product register
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign prod_o = st_ff.prod;
  assign done_o = st_ff.done;

endmodule : macu_mul

// file: verif/macu_tb_top.sv
`timescale 1ns/1ps
`include "macu_defines.svh"
module macu_tb_top;
  logic                    clk_i;            // 40 MHz core clock
  logic                    nrst_i;           // async reset, active low
  logic [`MACU_ADDR_W-1:0] avs_address_i;    // byte address
  logic                    avs_read_i;       // read strobe
  logic                    avs_write_i;      // write strobe
  logic [`MACU_BUS_W-1:0]  avs_writedata_i;  // write data
  logic [`MACU_BE_W-1:0]   avs_byteenable_i; // byte lanes
  logic [`MACU_BUS_W-1:0]  avs_readdata_o;   // read data
  logic                    avs_waitrequest_o;// stall
  int                      seed = 84;        // fixed seed, repeatable runs
  int                      fails;            // mismatch count
  int                      total_checks;     // comparison count
  logic [47:0]             m_acc;            // expected accumulator
  logic [15:0]             m_a;              // expected operand a
  logic [15:0]             m_b;              // expected operand b
  logic [15:0]             m_vm;             // expected middle view
  logic [15:0]             m_vl;             // expected low view
  logic [3:0]              m_ctrl;           // expected control word
  logic [31:0]             d;                // scratch read data

  macu_top dut_u (
    .clk_i            (clk_i),
    .nrst_i           (nrst_i),
    .avs_address_i    (avs_address_i),
    .avs_read_i       (avs_read_i),
    .avs_write_i      (avs_write_i),
    .avs_writedata_i  (avs_writedata_i),
    .avs_byteenable_i (avs_byteenable_i),
    .avs_readdata_o   (avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o)
  );

  // free running clock
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // verdict and end of run, the only exit
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // one compare, four-state so unknowns never match
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one bus cycle; waitrequest judged before each edge to avoid edge races
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [15:0] v,
                     input logic [3:0] be, output logic [31:0] rd);
    logic w;
    int   n;
    @(posedge clk_i);
    avs_address_i    <= {idx, 2'b00};
    avs_write_i      <= wr;
    avs_read_i       <= ~wr;
    avs_writedata_i  <= {16'h0000, v};
    avs_byteenable_i <= be;
    w = 1'b1;
    n = 0;
    while (w !== 1'b0)
    begin
      @(negedge clk_i);
      w = avs_waitrequest_o;
      rd = avs_readdata_o;
      @(posedge clk_i);
      n++;
      // stuck stall counts as a mismatch
      if (n > 100 && w !== 1'b0)
      begin
        fails++;
        complete_run();
      end
    end
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  // full-lane write
  task automatic wr(input logic [3:0] idx, input logic [15:0] v);
    logic [31:0] x;
    bus(1'b1, idx, v, 4'hF, x);
  endtask : wr

  // expected result of one operation, wraps mod 2^48
  function automatic logic [47:0] mac_res(input logic [3:0] c, input logic [15:0] a,
                                          input logic [15:0] b, input logic [47:0] acc);
    logic signed [31:0] sp;
    logic [31:0]        up;
    logic [47:0]        p;
    sp = $signed(a) * $signed(b);
    // unsigned product kept at full 32 bits before zero extension
    up = a * b;
    p = c[2] ? {{16{sp[31]}}, sp} : {16'h0000, up};
    case (c[1:0])
      macu_pkg::MACU_OP_MUL:  return p;
      macu_pkg::MACU_OP_MAC:  return acc + p;
      macu_pkg::MACU_OP_MSUB: return acc - p;
      default:                return 48'h000000000000 - p;
    endcase
  endfunction : mac_res

  // write operand b, which starts the armed operation, and update the model
  task automatic fire(input logic [15:0] b);
    logic [47:0] r;
    wr(`MACU_IDX_OPB, b);
    m_b = b;
    r = mac_res(m_ctrl, m_a, m_b, m_acc);
    m_vm = r[31:16];
    m_vl = r[15:0];
    if (!m_ctrl[3])
      m_acc = r;
  endtask : fire

  // program control, load a then b
  task automatic run_op(input logic [3:0] c, input logic [15:0] a, input logic [15:0] b);
    wr(`MACU_IDX_CTRL, {12'h000, c});
    m_ctrl = c;
    wr(`MACU_IDX_OPA, a);
    m_a = a;
    fire(b);
  endtask : run_op

  // read back every modelled register
  task automatic check_all();
    bus(1'b0, `MACU_IDX_OPA, 16'h0000, 4'hF, d);
    chk("operand_a", d, {16'h0000, m_a});
    bus(1'b0, `MACU_IDX_OPB, 16'h0000, 4'hF, d);
    chk("operand_b", d, {16'h0000, m_b});
    bus(1'b0, `MACU_IDX_ACC_U, 16'h0000, 4'hF, d);
    chk("acc_upper_word", d, {16'h0000, m_acc[47:32]});
    chk("acc_sign", {31'h0, d[15]}, {31'h0, m_acc[47]});
    bus(1'b0, `MACU_IDX_ACC_M, 16'h0000, 4'hF, d);
    chk("acc_middle_word", d, {16'h0000, m_acc[31:16]});
    bus(1'b0, `MACU_IDX_ACC_L, 16'h0000, 4'hF, d);
    chk("acc_lower_word", d, {16'h0000, m_acc[15:0]});
    bus(1'b0, `MACU_IDX_VW_M, 16'h0000, 4'hF, d);
    chk("result_view_middle", d, {16'h0000, m_vm});
    bus(1'b0, `MACU_IDX_VW_L, 16'h0000, 4'hF, d);
    chk("result_view_low", d, {16'h0000, m_vl});
    bus(1'b0, `MACU_IDX_CTRL, 16'h0000, 4'hF, d);
    chk("ctrl", d, {28'h0, m_ctrl});
  endtask : check_all

  // reset held twenty cycles, model cleared alongside
  task automatic do_reset();
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    {m_acc, m_a, m_b, m_vm, m_vl, m_ctrl} = '0;
  endtask : do_reset

  // main sequence
  initial
  begin
    logic [15:0] v;
    logic [3:0]  c;
    nrst_i = 1'b0;
    avs_address_i = '0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = '0;
    avs_byteenable_i = '0;
    fails = 0;
    total_checks = 0;
    do_reset();
    check_all();
    // corner operands for every op and signedness, accumulator preset
    for (int i = 0; i < 16; i++)
    begin
      wr(`MACU_IDX_ACC_U, 16'h7FFF);
      wr(`MACU_IDX_ACC_M, 16'hFFFF);
      wr(`MACU_IDX_ACC_L, 16'h0001);
      m_acc = 48'h7FFFFFFF0001;
      v = i[3] ? 16'hFFFF : 16'h8000;
      // signedness and inhibit crossed so every op meets both types
      run_op({i[2], i[3] ^ i[2], i[1:0]}, v, v);
      check_all();
    end
    // random operations, random inhibit, sometimes a fresh accumulator upper word
    for (int i = 0; i < 40; i++)
    begin
      c = $random(seed);
      if (i % 5 == 0)
      begin
        v = $random(seed);
        wr(`MACU_IDX_ACC_U, v);
        m_acc[47:32] = v;
      end
      run_op(c, $random(seed), $random(seed));
      check_all();
    end
    // views hold while only operand a changes
    v = $random(seed);
    wr(`MACU_IDX_OPA, v);
    m_a = v;
    check_all();
    fire($random(seed));
    check_all();
    // plain register writes, views untouched
    v = $random(seed);
    wr(`MACU_IDX_ACC_M, v);
    m_acc[31:16] = v;
    v = $random(seed);
    wr(`MACU_IDX_ACC_L, v);
    m_acc[15:0] = v;
    // upper lane only on operand b
    v = $random(seed);
    bus(1'b1, `MACU_IDX_OPB, v, 4'h2, d);
    m_b[15:8] = v[15:8];
    // unmapped and read-only places ignore writes
    wr(4'h6, 16'hA5A5);
    wr(`MACU_IDX_VW_M, 16'h1234);
    wr(`MACU_IDX_VW_L, 16'h4321);
    bus(1'b0, 4'h6, 16'h0000, 4'hF, d);
    chk("unmapped", d, 32'h00000000);
    check_all();
    // second reset in mid run
    do_reset();
    check_all();
    complete_run();
  end
endmodule : macu_tb_top
